// file: temp_limit_cfg.svh
// Offsets, field positions, reset values and counts of the temperature result monitor.
`ifndef TEMP_LIMIT_CFG_SVH
`define TEMP_LIMIT_CFG_SVH

`define RES_W            10
`define LIM_W            8
`define NUM_CH           6
`define FLAG_W           12
`define ACC_W            14
`define AVG_CNT_W        4
`define AVG_SHIFT        4
`define AVG_LAST         4'hF

`define CH_INT           3'h0
`define CH_EXT           3'h1
`define CH_AIN2          3'h2
`define CH_AIN3          3'h3
`define CH_AIN4          3'h4
`define CH_SUP           3'h5

`define ADDR_FLAGS_A     8'h00
`define ADDR_FLAGS_B     8'h01
`define ADDR_LSB_A       8'h03
`define ADDR_LSB_B       8'h04
`define ADDR_SUP_MSB     8'h06
`define ADDR_INT_MSB     8'h07
`define ADDR_EXT_MSB     8'h08
`define ADDR_AIN2_MSB    8'h09
`define ADDR_AIN3_MSB    8'h0A
`define ADDR_AIN4_MSB    8'h0B
`define ADDR_CFG1        8'h18
`define ADDR_CFG2        8'h19
`define ADDR_MASK_A      8'h1D
`define ADDR_MASK_B      8'h1E
`define ADDR_INT_OFS     8'h1F
`define ADDR_SUP_HI      8'h23
`define ADDR_SUP_LO      8'h24
`define ADDR_INT_HI      8'h25
`define ADDR_INT_LO      8'h26
`define ADDR_EXT_HI      8'h27
`define ADDR_EXT_LO      8'h28
`define ADDR_AIN2_HI     8'h2B
`define ADDR_AIN2_LO     8'h2C
`define ADDR_AIN3_HI     8'h2D
`define ADDR_AIN3_LO     8'h2E
`define ADDR_AIN4_HI     8'h2F
`define ADDR_AIN4_LO     8'h30

`define CFG1_POL_BIT     3
`define CFG2_AVG_DIS_BIT 5

`define RST_BYTE         8'h00
`define RST_SUP_HI       8'hC7
`define RST_SUP_LO       8'h62
`define RST_INT_HI       8'h64
`define RST_INT_LO       8'hC9
`define RST_AIN_HI       8'hFF
`define RST_AIN_LO       8'h00

`endif

// file: temp_limit_pkg.sv
// Types shared by the temperature result monitor.
`include "temp_limit_cfg.svh"

package temp_limit_pkg;

	typedef struct packed {
		logic [7:0]                              rd_data;
		logic [`FLAG_W-1:0]                      flags;
		logic [7:0]                              mask_a;
		logic [7:0]                              mask_b;
		logic [7:0]                              cfg1;
		logic [7:0]                              cfg2;
		logic [7:0]                              int_ofs;
		logic [`NUM_CH-1:0][`LIM_W-1:0]          lim_hi;
		logic [`NUM_CH-1:0][`LIM_W-1:0]          lim_lo;
		logic [`NUM_CH-1:0][`RES_W-1:0]          result;
		logic [1:0][`ACC_W-1:0]                  acc;
		logic [1:0][`AVG_CNT_W-1:0]              cnt;
		logic                                    irq;
	} state_t;

endpackage

// file: temp_result_limit_monitor.sv
// Temperature and supply result formatting, averaging and limit monitor.
`timescale 1ns/1ps
`include "temp_limit_cfg.svh"

module temp_result_limit_monitor
	import temp_limit_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	// Converter results.
	input  wire logic             conv_valid_in,
	input  wire logic [2:0]       conv_channel_in,
	input  wire logic [`RES_W-1:0] conv_data_in,
	// Register port from the serial link.
	input  wire logic             reg_wr_in,
	input  wire logic             reg_rd_in,
	input  wire logic [7:0]       reg_addr_in,
	input  wire logic [7:0]       reg_wdata_in,
	output logic      [7:0]       reg_rdata_out,
	// Interrupt pin.
	output logic                  irq_out
);

	state_t st_ff;
	state_t nxt_st;

	// Bit 0 is the high event, bit 1 the low event.
	function automatic logic [1:0] limit_check(input logic [`RES_W-1:0] res,
		input logic [`LIM_W-1:0] hi, input logic [`LIM_W-1:0] lo, input logic sgn);
		logic [`LIM_W-1:0] top;
		top = res[`RES_W-1:`RES_W-`LIM_W];
		if (sgn)
		begin
			limit_check[0] = $signed(top) > $signed(hi);
			limit_check[1] = $signed(top) <= $signed(lo);
		end
		else
		begin
			limit_check[0] = top > hi;
			limit_check[1] = top <= lo;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [`ACC_W-1:0]  acc_new;
		logic [`RES_W-1:0]  value;
		logic               store;
		logic               tch;
		logic [2:0]         ch;
		logic [1:0]         hit;
		logic [`FLAG_W-1:0] set;
		logic [15:0]        mask;
		acc_new = '0;
		value   = conv_data_in;
		store   = 1'b0;
		ch      = conv_channel_in;
		tch     = (ch == `CH_INT) || (ch == `CH_EXT);
		hit     = 2'b00;
		set     = '0;
		nxt_st  = st_ff;
		mask    = {st_ff.mask_b, st_ff.mask_a};

		// Converter side.
		if (conv_valid_in && (ch <= `CH_SUP))
		begin
			if (tch && !st_ff.cfg2[`CFG2_AVG_DIS_BIT])
			begin
				// Raw codes are signed quarter degrees, so the sum keeps the scale.
				acc_new = st_ff.acc[ch[0]] + {{(`ACC_W-`RES_W){conv_data_in[`RES_W-1]}},
					conv_data_in};
				if (st_ff.cnt[ch[0]] == `AVG_LAST)
				begin
					value = acc_new[`RES_W+`AVG_SHIFT-1:`AVG_SHIFT];
					store = 1'b1;
					nxt_st.acc[ch[0]] = '0;
				end
				else
				begin
					nxt_st.acc[ch[0]] = acc_new;
				end
				nxt_st.cnt[ch[0]] = st_ff.cnt[ch[0]] + 1'b1;
			end
			else
			begin
				store = 1'b1;
			end
			if (store && (ch == `CH_INT))
			begin
				// Offset shares the quarter degree step; the sum wraps at the extremes.
				value = value + {{(`RES_W-8){st_ff.int_ofs[7]}}, st_ff.int_ofs};
			end
			if (store)
			begin
				nxt_st.result[ch] = value;
				hit = limit_check(value, st_ff.lim_hi[ch], st_ff.lim_lo[ch], tch);
				set[{ch, 1'b0}]  = hit[0] & ~mask[{ch, 1'b0}];
				set[{ch, 1'b1}]  = hit[1] & ~mask[{ch, 1'b1}];
			end
		end

		// Register reads; status bytes clear on read but a new event still lands.
		nxt_st.rd_data = 8'h00;
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				`ADDR_FLAGS_A:
				begin
					nxt_st.rd_data = st_ff.flags[7:0];
					nxt_st.flags[7:0] = 8'h00;
				end
				`ADDR_FLAGS_B:
				begin
					nxt_st.rd_data = {4'h0, st_ff.flags[`FLAG_W-1:8]};
					nxt_st.flags[`FLAG_W-1:8] = 4'h0;
				end
				`ADDR_LSB_A:    nxt_st.rd_data = {4'h0, st_ff.result[`CH_SUP][1:0],
					st_ff.result[`CH_INT][1:0]};
				`ADDR_LSB_B:    nxt_st.rd_data = {st_ff.result[`CH_AIN4][1:0],
					st_ff.result[`CH_AIN3][1:0], st_ff.result[`CH_AIN2][1:0],
					st_ff.result[`CH_EXT][1:0]};
				`ADDR_SUP_MSB:  nxt_st.rd_data = st_ff.result[`CH_SUP][9:2];
				`ADDR_INT_MSB:  nxt_st.rd_data = st_ff.result[`CH_INT][9:2];
				`ADDR_EXT_MSB:  nxt_st.rd_data = st_ff.result[`CH_EXT][9:2];
				`ADDR_AIN2_MSB: nxt_st.rd_data = st_ff.result[`CH_AIN2][9:2];
				`ADDR_AIN3_MSB: nxt_st.rd_data = st_ff.result[`CH_AIN3][9:2];
				`ADDR_AIN4_MSB: nxt_st.rd_data = st_ff.result[`CH_AIN4][9:2];
				`ADDR_CFG1:     nxt_st.rd_data = st_ff.cfg1;
				`ADDR_CFG2:     nxt_st.rd_data = st_ff.cfg2;
				`ADDR_MASK_A:   nxt_st.rd_data = st_ff.mask_a;
				`ADDR_MASK_B:   nxt_st.rd_data = st_ff.mask_b;
				`ADDR_INT_OFS:  nxt_st.rd_data = st_ff.int_ofs;
				`ADDR_SUP_HI:   nxt_st.rd_data = st_ff.lim_hi[`CH_SUP];
				`ADDR_SUP_LO:   nxt_st.rd_data = st_ff.lim_lo[`CH_SUP];
				`ADDR_INT_HI:   nxt_st.rd_data = st_ff.lim_hi[`CH_INT];
				`ADDR_INT_LO:   nxt_st.rd_data = st_ff.lim_lo[`CH_INT];
				`ADDR_EXT_HI:   nxt_st.rd_data = st_ff.lim_hi[`CH_EXT];
				`ADDR_EXT_LO:   nxt_st.rd_data = st_ff.lim_lo[`CH_EXT];
				`ADDR_AIN2_HI:  nxt_st.rd_data = st_ff.lim_hi[`CH_AIN2];
				`ADDR_AIN2_LO:  nxt_st.rd_data = st_ff.lim_lo[`CH_AIN2];
				`ADDR_AIN3_HI:  nxt_st.rd_data = st_ff.lim_hi[`CH_AIN3];
				`ADDR_AIN3_LO:  nxt_st.rd_data = st_ff.lim_lo[`CH_AIN3];
				`ADDR_AIN4_HI:  nxt_st.rd_data = st_ff.lim_hi[`CH_AIN4];
				`ADDR_AIN4_LO:  nxt_st.rd_data = st_ff.lim_lo[`CH_AIN4];
				default:        nxt_st.rd_data = 8'h00;
			endcase
		end

		// Register writes.
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				`ADDR_CFG1:    nxt_st.cfg1 = reg_wdata_in;
				`ADDR_CFG2:
				begin
					nxt_st.cfg2 = reg_wdata_in;
					// A half-filled sum would mix old and new modes, so restart it.
					if (reg_wdata_in[`CFG2_AVG_DIS_BIT] != st_ff.cfg2[`CFG2_AVG_DIS_BIT])
					begin
						nxt_st.acc = '0;
						nxt_st.cnt = '0;
					end
				end
				`ADDR_MASK_A:  nxt_st.mask_a = reg_wdata_in;
				`ADDR_MASK_B:  nxt_st.mask_b = reg_wdata_in;
				`ADDR_INT_OFS: nxt_st.int_ofs = reg_wdata_in;
				`ADDR_SUP_HI:  nxt_st.lim_hi[`CH_SUP] = reg_wdata_in;
				`ADDR_SUP_LO:  nxt_st.lim_lo[`CH_SUP] = reg_wdata_in;
				`ADDR_INT_HI:  nxt_st.lim_hi[`CH_INT] = reg_wdata_in;
				`ADDR_INT_LO:  nxt_st.lim_lo[`CH_INT] = reg_wdata_in;
				`ADDR_EXT_HI:  nxt_st.lim_hi[`CH_EXT] = reg_wdata_in;
				`ADDR_EXT_LO:  nxt_st.lim_lo[`CH_EXT] = reg_wdata_in;
				`ADDR_AIN2_HI: nxt_st.lim_hi[`CH_AIN2] = reg_wdata_in;
				`ADDR_AIN2_LO: nxt_st.lim_lo[`CH_AIN2] = reg_wdata_in;
				`ADDR_AIN3_HI: nxt_st.lim_hi[`CH_AIN3] = reg_wdata_in;
				`ADDR_AIN3_LO: nxt_st.lim_lo[`CH_AIN3] = reg_wdata_in;
				`ADDR_AIN4_HI: nxt_st.lim_hi[`CH_AIN4] = reg_wdata_in;
				`ADDR_AIN4_LO: nxt_st.lim_lo[`CH_AIN4] = reg_wdata_in;
				default:       nxt_st.cfg1 = nxt_st.cfg1;
			endcase
		end

		nxt_st.flags = nxt_st.flags | set;
		nxt_st.irq = (|nxt_st.flags) ~^ nxt_st.cfg1[`CFG1_POL_BIT];

		if (!rst_b_in)
		begin
			nxt_st         = '0;
			nxt_st.lim_hi  = {`NUM_CH{`RST_AIN_HI}};
			nxt_st.lim_lo  = {`NUM_CH{`RST_AIN_LO}};
			nxt_st.lim_hi[`CH_SUP] = `RST_SUP_HI;
			nxt_st.lim_lo[`CH_SUP] = `RST_SUP_LO;
			nxt_st.lim_hi[`CH_INT] = `RST_INT_HI;
			nxt_st.lim_lo[`CH_INT] = `RST_INT_LO;
			nxt_st.cfg2    = `RST_BYTE;
			nxt_st.irq     = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_in)
	begin
		st_ff <= nxt_st;
	end

	assign reg_rdata_out = st_ff.rd_data;
	assign irq_out       = st_ff.irq;

endmodule

// file: temp_limit_monitor_assertions.sv
// Concurrent checks on the register port and interrupt pin of the limit monitor.
`timescale 1ns/1ps
`include "temp_limit_cfg.svh"
module temp_limit_assertions
(
	// Watched ports.
	input wire logic               clk_in,
	input wire logic               rst_b_in,
	input wire logic               conv_valid_in,
	input wire logic [2:0]         conv_channel_in,
	input wire logic [`RES_W-1:0]  conv_data_in,
	input wire logic               reg_wr_in,
	input wire logic               reg_rd_in,
	input wire logic [7:0]         reg_addr_in,
	input wire logic [7:0]         reg_wdata_in,
	input wire logic [7:0]         reg_rdata_out,
	input wire logic               irq_out
);
	logic pol_ff;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// The polarity is mirrored so that the idle level of the pin can be judged.
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
			pol_ff <= 1'b0;
		else if (reg_wr_in && reg_addr_in == `ADDR_CFG1)
			pol_ff <= reg_wdata_in[`CFG1_POL_BIT];
	end
	////////////////////////////////////////////////////////////////////////////////
	rdata_idle_a: assert property (
		!reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data not idle");
	unmapped_read_a: assert property (
		reg_rd_in && reg_addr_in == 8'h02 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	flags_b_upper_a: assert property (
		reg_rd_in && reg_addr_in == `ADDR_FLAGS_B |=> reg_rdata_out[7:4] == 4'h0)
		else $error("upper status bits set");
	flags_clear_a: assert property (
		reg_rd_in && reg_addr_in == `ADDR_FLAGS_A && !conv_valid_in
		##1 !conv_valid_in
		##1 reg_rd_in && reg_addr_in == `ADDR_FLAGS_A |=> reg_rdata_out == 8'h00)
		else $error("status not cleared");
	irq_cause_a: assert property (
		$changed(irq_out) |-> $past(conv_valid_in || reg_rd_in || reg_wr_in))
		else $error("interrupt moved without cause");
	irq_idle_a: assert property (
		reg_rd_in && reg_addr_in == `ADDR_FLAGS_A && !conv_valid_in
		##1 !conv_valid_in
		##1 reg_rd_in && reg_addr_in == `ADDR_FLAGS_B && !conv_valid_in && !reg_wr_in
		|=> irq_out == !pol_ff)
		else $error("interrupt not idle after clear");
	stands_one_a: assert property (
		reg_rdata_out != 8'h00 |-> $past(reg_rd_in))
		else $error("read data stands too long");
	bad_channel_a: assert property (
		conv_valid_in && conv_channel_in[2:1] == 2'b11 && !reg_rd_in && !reg_wr_in
		|=> $stable(irq_out))
		else $error("ignored channel moved interrupt");
endmodule

// file: temp_limit_host.sv
// Host model that reaches the monitor's registers over its register port.
`timescale 1ns/1ps
module temp_limit_host
(
	// Clock.
	input  wire logic       clk_in,
	// Register port toward the device.
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic [7:0]      reg_addr_out,
	output logic [7:0]      reg_wdata_out,
	input  wire logic [7:0] reg_rdata_in
);
	initial
	begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'hA5;
		reg_wdata_out = 8'h5A;
	end
	// Released lines show the inverse so a stale value is never mistaken for a live one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr_out <= 1'b1;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge clk_in);
		reg_wr_out <= 1'b0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_rd_out <= 1'b1;
		reg_addr_out <= a;
		@(posedge clk_in);
		reg_rd_out <= 1'b0;
		reg_addr_out <= ~a;
		@(negedge clk_in);
		d = reg_rdata_in;
	endtask
endmodule

// file: temp_result_limit_monitor_tb.sv
// Self-checking bench of the temperature result limit monitor.
`timescale 1ns/1ps
module temp_result_limit_monitor_tb;
	logic       clk_in;
	logic       rst_b_in;
	logic       conv_valid_in;
	logic [2:0] conv_channel_in;
	logic [9:0] conv_data_in;
	logic       reg_wr_in;
	logic       reg_rd_in;
	logic [7:0] reg_addr_in;
	logic [7:0] reg_wdata_in;
	logic [7:0] reg_rdata_out;
	logic       irq_out;
	int         bad_count;
	int         checks_done;
	int         cycles;
	logic [7:0] ra[12] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h23, 8'h24,
		8'h25, 8'h26, 8'h27, 8'h28, 8'h2B, 8'h2C};
	logic [7:0] re[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC7, 8'h62,
		8'h64, 8'hC9, 8'hFF, 8'h00, 8'hFF, 8'h00};
	temp_result_limit_monitor i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.conv_valid_in(conv_valid_in), .conv_channel_in(conv_channel_in),
		.conv_data_in(conv_data_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
	temp_limit_host i_host (.clk_in(clk_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
		.reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		i_host.rd(a, v);
		chk(v, e);
	endtask
	task automatic ci(input logic e);
		@(negedge clk_in);
		chk({7'h00, irq_out}, {7'h00, e});
	endtask
	task automatic cv(input logic [2:0] ch, input logic [9:0] d);
		@(posedge clk_in);
		conv_valid_in <= 1'b1;
		conv_channel_in <= ch;
		conv_data_in <= d;
		@(posedge clk_in);
		conv_valid_in <= 1'b0;
		conv_data_in <= ~d;
	endtask
	task automatic results;
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// The ceiling is nearly seventeen times the length of the sequence below.
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			results;
		end
	end
	initial
	begin
		rst_b_in = 1'b0;
		conv_valid_in = 1'b0;
		conv_channel_in = 3'h0;
		conv_data_in = 10'h000;
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 12; i++) rc(ra[i], re[i]);
		ci(1'b1);
		i_host.wr(8'h19, 8'h20);
		i_host.wr(8'h1F, 8'h04);
		cv(3'h0, 10'h064);
		rc(8'h07, 8'h1A);
		rc(8'h00, 8'h00);
		cv(3'h0, 10'h190);
		ci(1'b0);
		rc(8'h00, 8'h01);
		rc(8'h00, 8'h00);
		ci(1'b1);
		cv(3'h0, 10'h18C);
		rc(8'h00, 8'h00);
		rc(8'h07, 8'h64);
		cv(3'h1, 10'h360);
		rc(8'h08, 8'hD8);
		rc(8'h00, 8'h08);
		cv(3'h2, 10'h000);
		rc(8'h00, 8'h20);
		cv(3'h2, 10'h3FC);
		rc(8'h00, 8'h00);
		i_host.wr(8'h1D, 8'h08);
		cv(3'h1, 10'h360);
		rc(8'h00, 8'h00);
		ci(1'b1);
		i_host.wr(8'h18, 8'h08);
		ci(1'b0);
		cv(3'h5, 10'h3FC);
		ci(1'b1);
		rc(8'h01, 8'h04);
		ci(1'b0);
		i_host.wr(8'h19, 8'h00);
		for (int i = 0; i < 15; i++) cv(3'h0, i[0] ? 10'h00C : 10'h008);
		rc(8'h07, 8'h64);
		cv(3'h0, 10'h00C);
		rc(8'h07, 8'h03);
		rc(8'h03, 8'h02);
		cv(3'h6, 10'h000);
		rc(8'h00, 8'h00);
		rc(8'h01, 8'h00);
		// The external channel keeps its own sum, so sixteen pulses of it store once.
		for (int i = 0; i < 16; i++) cv(3'h1, 10'h028);
		rc(8'h08, 8'h0A);
		rc(8'h00, 8'h04);
		i_host.wr(8'h2F, 8'h10);
		i_host.wr(8'h1E, 8'h01);
		cv(3'h4, 10'h2C7);
		rc(8'h01, 8'h00);
		rc(8'h0B, 8'hB1);
		rc(8'h04, 8'hC0);
		rc(8'h2F, 8'h10);
		results;
	end
endmodule
bind temp_result_limit_monitor temp_limit_assertions i_chk (.clk_in(clk_in),
	.rst_b_in(rst_b_in), .conv_valid_in(conv_valid_in),
	.conv_channel_in(conv_channel_in), .conv_data_in(conv_data_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
